//--- flash_array_model.sv
// Behavioural flash array answering the reads forwarded by the guard
`timescale 1ns/100ps
module flash_array_model
(
    // Clock
    input wire logic sys_clk,
    // Access forwarded from the guard
    input wire logic [15:0] memAddr,
    input wire logic memRead,
    output logic [7:0] memRdData
);
    // ----------------------------------------
    // Read answer
    // ----------------------------------------
    logic [7:0] idleJunk = 8'h00; // Idle pattern, flips every cycle
    // Idle bus toggles so stale data can never pass for an answer
    always @(posedge sys_clk)
        idleJunk <= ~idleJunk;
    // Data is a fixed function of the address, junk when not read
    assign memRdData = memRead ? (memAddr[7:0] ^ 8'h3c) : idleJunk;
endmodule

//--- flash_guard.sv
// Flash block protection, vector redirection and security gate
`timescale 1ns/100ps
module flash_guard
    import flash_guard_pkg::*;
#(
    parameter logic [15:0] FLASH_LO = 16'hc000, // Lowest flash address
    parameter logic [15:0] RAM_LO = 16'h0070,   // Lowest RAM address
    parameter logic [15:0] RAM_HI = 16'h046f    // Highest RAM address
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Nonvolatile bytes read out of the array, and the background mode pin
    input wire logic [7:0] protNvByte,
    input wire logic [7:0] optNvByte,
    input wire logic [63:0] backdoorKeyBytes,
    input wire logic backgroundModePin,
    // Bus access from CPU or debug controller
    input wire logic [15:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic [7:0] busWrData,
    input wire logic busFromBdc,
    input wire logic busFromSecure,
    input wire logic busVectorFetch,
    output logic [7:0] busRdData,
    // Memory array side
    output logic [15:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic [7:0] memWrData,
    input wire logic [7:0] memRdData,
    // Program and erase request check
    input wire logic peReq,
    input wire logic [15:0] peAddr,
    output logic peAccept,
    output logic peReject,
    // Blank check result
    input wire logic blankDone,
    input wire logic blankErased,
    input wire logic blankFromBdc,
    // Status
    output logic secureEngaged,
    output logic debugEnableAllowed,
    output logic activeBgAllowed
);
    import flash_guard_pkg::*;
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic loadPending;          // Nonvolatile copy not yet done
    logic [7:0] protReg;        // Working protection register
    logic [7:0] optReg;         // Working options register
    logic key_compare_access;               // Key compare access bit
    logic unlocked;             // Security forced open until reset
    logic bgPinLow;             // Pin level caught at reset release
    logic rdZeroQ;              // Pending read answers zero
    logic rdRegQ;               // Pending read hits a working reg
    logic [7:0] rdRegDataQ;     // Working reg value for that read
    logic rdPendQ;              // Any bus read in flight
    logic unlockPulse;          // From key comparator
    logic [15:0] steerAddr;     // Possibly redirected address
    // Next values
    logic next_loadPending;
    logic [7:0] next_protReg;
    logic [7:0] next_optReg;
    logic next_key_compare_access;
    logic next_unlocked;
    logic next_bgPinLow;
    // Decode terms
    logic [6:0] limitBits;
    logic [15:0] lastOpen;
    logic protOn;
    logic allProtected;
    logic redirectOn;
    logic secureNow;
    logic targetSecure;
    logic sourceOpen;
    logic blocked;
    logic keyHit;
    logic keyCapture;
    logic regHit;
    logic [7:0] regData;
    // ----------------------------------------
    // Protection decode
    // ----------------------------------------
    assign limitBits = protReg[7:1];
    assign lastOpen = {limitBits, PAGE_FILL};
    assign protOn = !protReg[PROT_DIS_BIT];
    assign allProtected = lastOpen < FLASH_LO;
    // Some but not all: limit not at the top and region not covering flash
    assign redirectOn = !optReg[OPT_NORED_BIT] && protOn
        && lastOpen != FLASH_TOP_ADDR && !allProtected;
    // ----------------------------------------
    // Security decode
    // ----------------------------------------
    assign secureNow = !unlocked && optReg[1:0] != SEC_OPEN;
    assign targetSecure = busAddr >= FLASH_LO || (busAddr >= RAM_LO && busAddr <= RAM_HI);
    assign sourceOpen = busFromBdc || !busFromSecure;
    // Secure code is never blocked, whatever the state
    assign blocked = secureNow && targetSecure && sourceOpen;
    assign keyHit = busAddr >= KEY_BASE_ADDR && busAddr < KEY_BASE_ADDR + 16'(KEY_BYTES);
    // Debug and unsecured code never reach the comparator
    assign keyCapture = key_compare_access && keyHit && busWrite && !sourceOpen;
    // ----------------------------------------
    // Working register read mux
    // ----------------------------------------
    always_comb
    begin
        regHit = 1'b1;
        regData = RESET_BYTE;
        unique case (busAddr)
            PROT_REG_ADDR: regData = protReg;
            OPT_REG_ADDR: regData = {optReg[7:6], 4'h0, secureNow ? optReg[1:0] : SEC_OPEN}
                & OPT_READ_MASK;
            CFG_REG_ADDR: regData = {2'h0, key_compare_access, 5'h0} & CFG_READ_MASK;
            default: regHit = 1'b0;
        endcase
    end
    // ----------------------------------------
    // Vector steering
    // ----------------------------------------
    vector_redirect u_redirect (
        .fetchAddr(busAddr),
        .isVectorFetch(busVectorFetch),
        .redirectOn(redirectOn),
        .limitBits(limitBits),
        .steerAddr(steerAddr)
    );
    // ----------------------------------------
    // Backdoor key comparison
    // ----------------------------------------
    key_match u_key (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .key_compare_access(key_compare_access),
        .keyAllowed(optReg[OPT_BACKDOOR_ALLOW_BIT]),
        .keyWrite(keyCapture),
        .keyIdx(busAddr[2:0]),
        .keyData(busWrData),
        .storedKey(backdoorKeyBytes),
        .unlockPulse(unlockPulse)
    );
    // ----------------------------------------
    // Control register next state
    // ----------------------------------------
    // One load cycle after release stands in for the reset copy
    always_comb
    begin
        next_loadPending = 1'b0;
        next_protReg = protReg;
        next_optReg = optReg;
        next_key_compare_access = key_compare_access;
        next_unlocked = unlocked;
        next_bgPinLow = bgPinLow;
        if (loadPending)
        begin
            next_protReg = protNvByte;
            next_optReg = optNvByte;
            next_bgPinLow = !backgroundModePin;
            next_key_compare_access = 1'b0;
        end
        else
        begin
            // Software writes land here too but are dropped
            if (busWrite && busAddr == PROT_REG_ADDR && busFromBdc)
            begin
                next_protReg = busWrData;
            end
            // Options register ignores all writes
            if (busWrite && busAddr == CFG_REG_ADDR && !blocked)
            begin
                next_key_compare_access = busWrData[CFG_KEY_COMPARE_ACCESS_BIT];
            end
            // Set wins, only reset clears it
            if (unlockPulse)
            begin
                next_unlocked = 1'b1;
            end
            if (blankDone && blankErased && blankFromBdc)
            begin
                next_unlocked = 1'b1;
            end
        end
    end
    // Registers only
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loadPending <= 1'b1;
            protReg <= RESET_BYTE;
            optReg <= RESET_BYTE;
            key_compare_access <= 1'b0;
            unlocked <= 1'b0;
            bgPinLow <= 1'b0;
        end
        else
        begin
            loadPending <= next_loadPending;
            protReg <= next_protReg;
            optReg <= next_optReg;
            key_compare_access <= next_key_compare_access;
            unlocked <= next_unlocked;
            bgPinLow <= next_bgPinLow;
        end
    end
    // ----------------------------------------
    // Bus forwarding and read answer
    // ----------------------------------------
    // Memory sees the access one cycle later, the read answer one more
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            memAddr <= 16'h0000;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            memWrData <= 8'h00;
            rdZeroQ <= 1'b0;
            rdRegQ <= 1'b0;
            rdRegDataQ <= 8'h00;
            rdPendQ <= 1'b0;
            busRdData <= 8'h00;
        end
        else
        begin
            memAddr <= steerAddr;
            memRead <= busRead && !blocked && !regHit;
            // Key writes while comparing never start a command
            memWrite <= busWrite && !blocked && !regHit
                && !(key_compare_access && keyHit);
            memWrData <= busWrData;
            rdZeroQ <= busRead && blocked;
            rdRegQ <= busRead && regHit;
            rdRegDataQ <= regData;
            rdPendQ <= busRead;
            if (rdPendQ)
            begin
                busRdData <= rdZeroQ ? 8'h00 : (rdRegQ ? rdRegDataQ : memRdData);
            end
        end
    end
    // ----------------------------------------
    // Program and erase gate, status
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            peAccept <= 1'b0;
            peReject <= 1'b0;
            secureEngaged <= 1'b1;
            debugEnableAllowed <= 1'b0;
            activeBgAllowed <= 1'b0;
        end
        else
        begin
            peAccept <= peReq && !(protOn && peAddr > lastOpen);
            peReject <= peReq && protOn && peAddr > lastOpen;
            secureEngaged <= secureNow;
            debugEnableAllowed <= !secureNow;
            activeBgAllowed <= !secureNow || bgPinLow;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_PE_REJECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (peReq && protOn && peAddr > lastOpen) |=> (peReject && !peAccept))
        else $error("protected program or erase not rejected");
    AST_NV_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        loadPending |=> (protReg == $past(protNvByte) && optReg == $past(optNvByte)))
        else $error("working registers not loaded from nonvolatile bytes");
    AST_PROT_SW_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!loadPending && busWrite && !busFromBdc) |=> $stable(protReg))
        else $error("protection register changed by software");
    AST_REDIRECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busVectorFetch && redirectOn && busAddr >= VEC_LO_ADDR && busAddr <= VEC_HI_ADDR)
        |=> memAddr == {$past(limitBits), VEC_FILL, $past(busAddr[5:0])})
        else $error("vector fetch not redirected below region");
    AST_RESET_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busVectorFetch && busAddr > VEC_HI_ADDR) |=> memAddr == $past(busAddr))
        else $error("reset vector was redirected");
    AST_BLOCKED_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busRead && blocked) |=> ##1 busRdData == 8'h00)
        else $error("blocked read returned data");
    AST_BLOCKED_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busWrite && blocked) |=> !memWrite)
        else $error("blocked write reached memory");
    AST_SECURE_OPEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busWrite && busFromSecure && !busFromBdc && !regHit && !(key_compare_access && keyHit))
        |=> memWrite)
        else $error("secure code write was blocked");
    AST_SEC_PAIR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!loadPending && !unlocked && optReg[1:0] != SEC_OPEN) |=> secureEngaged)
        else $error("security not engaged for locked pair");
    AST_KEY_NO_CMD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busWrite && key_compare_access && keyHit) |=> !memWrite)
        else $error("key write started a flash command");
    AST_BLANK_UNLOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!loadPending && blankDone && blankErased && blankFromBdc) |=> ##1 !secureEngaged)
        else $error("erased blank check did not unlock");
    AST_DEBUG_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
        secureEngaged |-> !debugEnableAllowed)
        else $error("debug enable allowed while secure");
endmodule

//--- flash_guard_pkg.sv
// Constants shared by the flash protection and security unit
// What this block does
// - Reject program/erase inside protected top region
// - Load working protection register after reset
// - Protection register writable only from debug
// - Last unprotected address: limit bits, ones below
// - Protection active only when disable bit zero
// - Redirect only if enabled and partially protected
// - Redirect interrupt vectors, never the reset vector
// - Redirected fetch uses same offset below region
// - Secure: block unsecured access, reads return zero
// - Code in secure memory keeps full access
// - Options register copied at reset, sets security
// - Only pair 1:0 disengages security
// - Secure: no debug enable, background only by pin
// - Backdoor disallowed: ignore every key attempt
// - Key-compare on: key writes captured, no command
// - Key match on compare exit forces pair 1:0
// - Keys only from secure code, not debug
// - Erased blank check from debug unlocks security
package flash_guard_pkg;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam logic [15:0] PROT_NV_ADDR = 16'hffbd;   // Nonvolatile protection byte
    localparam logic [15:0] OPT_NV_ADDR = 16'hffbf;    // Nonvolatile options byte
    localparam logic [15:0] KEY_BASE_ADDR = 16'hffb0;  // First backdoor key byte
    localparam logic [15:0] PROT_REG_ADDR = 16'h1824;  // Working protection register
    localparam logic [15:0] OPT_REG_ADDR = 16'h1821;   // Working options register
    localparam logic [15:0] CFG_REG_ADDR = 16'h1823;   // Flash configuration register
    localparam logic [15:0] VEC_LO_ADDR = 16'hffc0;    // First interrupt vector byte
    localparam logic [15:0] VEC_HI_ADDR = 16'hfffd;    // Last interrupt vector byte
    localparam logic [15:0] FLASH_TOP_ADDR = 16'hffff; // Protected region always ends here
    // ----------------------------------------
    // Field positions and values
    // ----------------------------------------
    localparam int PROT_DIS_BIT = 0;                   // Protection disable bit
    localparam int OPT_NORED_BIT = 6;                  // Vector redirect disable
    localparam int OPT_BACKDOOR_ALLOW_BIT = 7;                  // Backdoor allow
    localparam int CFG_KEY_COMPARE_ACCESS_BIT = 5;                 // Key compare access
    localparam logic [1:0] SEC_OPEN = 2'h2;            // Only unsecured encoding
    localparam logic [7:0] OPT_READ_MASK = 8'hc3;      // Bits 5..2 read zero
    localparam logic [7:0] CFG_READ_MASK = 8'h20;      // Only key access implemented
    localparam logic [7:0] RESET_BYTE = 8'h00;         // Reset value of working regs
    localparam int KEY_BYTES = 8;                      // Backdoor key length
    localparam logic [2:0] VEC_FILL = 3'h7;            // Table sits just below region
    localparam logic [8:0] PAGE_FILL = 9'h1ff;         // Ones below the limit bits
endpackage

//--- flash_guard_tb_top.sv
// Self-checking testbench for the flash protection and security unit
`timescale 1ns/100ps
module flash_guard_tb_top;
    import flash_guard_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] protNvByte = 8'hff;
    logic [7:0] optNvByte = 8'h02;
    logic [63:0] backdoorKeyBytes = 64'h8877665544332211; // Byte i is 11h times i+1
    logic backgroundModePin = 1'b1;
    logic [15:0] busAddr = 16'h0000;
    logic busRead = 1'b0;
    logic busWrite = 1'b0;
    logic [7:0] busWrData = 8'h00;
    logic busFromBdc = 1'b0;
    logic busFromSecure = 1'b0;
    logic busVectorFetch = 1'b0;
    logic [7:0] busRdData;
    logic [15:0] memAddr;
    logic memRead;
    logic memWrite;
    logic [7:0] memWrData;
    logic [7:0] memRdData;
    logic peReq = 1'b0;
    logic [15:0] peAddr = 16'h0000;
    logic peAccept;
    logic peReject;
    logic blankDone = 1'b0;
    logic blankErased = 1'b0;
    logic blankFromBdc = 1'b0;
    logic secureEngaged;
    logic debugEnableAllowed;
    logic activeBgAllowed;
    logic seenWr; // Forwarded write seen after an access
    logic [15:0] seenAddr; // Forwarded address seen after an access
    logic [7:0] seenData; // Forwarded write data seen after an access
    int errors = 0;
    int testsRun = 0;
    // Rows: protection byte, target address, expected reject
    logic [24:0] peRows [6] = '{{8'hf8, 16'hfa00, 1'b1}, {8'hf8, 16'hf9ff, 1'b0},
        {8'hf8, 16'hffff, 1'b1}, {8'hf9, 16'hffff, 1'b0}, {8'hfc, 16'hfe00, 1'b1},
        {8'hfc, 16'hfdff, 1'b0}};
    // ----------------------------------------
    // Design, far side and clock
    // ----------------------------------------
    flash_guard flash_guard_i (.sys_clk(sys_clk), .rst_b(rst_b), .protNvByte(protNvByte),
        .optNvByte(optNvByte), .backdoorKeyBytes(backdoorKeyBytes),
        .backgroundModePin(backgroundModePin), .busAddr(busAddr), .busRead(busRead),
        .busWrite(busWrite), .busWrData(busWrData), .busFromBdc(busFromBdc),
        .busFromSecure(busFromSecure), .busVectorFetch(busVectorFetch),
        .busRdData(busRdData), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
        .memWrData(memWrData), .memRdData(memRdData), .peReq(peReq), .peAddr(peAddr),
        .peAccept(peAccept), .peReject(peReject), .blankDone(blankDone),
        .blankErased(blankErased), .blankFromBdc(blankFromBdc),
        .secureEngaged(secureEngaged), .debugEnableAllowed(debugEnableAllowed),
        .activeBgAllowed(activeBgAllowed));
    flash_array_model flash_array_model_i (.sys_clk(sys_clk), .memAddr(memAddr),
        .memRead(memRead), .memRdData(memRdData));
    // Bus clock, 50 ns period
    always #25 sys_clk = ~sys_clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reset with given nonvolatile bytes; returns once requests are allowed
    task automatic boot(input logic [7:0] prot, input logic [7:0] opt, input logic pin);
        rst_b = 1'b0;
        protNvByte = prot;
        optNvByte = opt;
        backgroundModePin = pin;
        repeat (4) @(negedge sys_clk);
        chk({secureEngaged, memRead, memWrite, peReject}, 16'h0008);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask
    // One bus access; the gap after it keeps key writes off adjacent cycles
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
        input logic bdc, input logic sec, input logic vec);
        busAddr = a;
        busWrData = d;
        busFromBdc = bdc;
        busFromSecure = sec;
        busVectorFetch = vec;
        busRead = !wr;
        busWrite = wr;
        @(negedge sys_clk);
        // Forwarded access stands for one cycle only, so catch it now
        seenWr = memWrite;
        seenAddr = memAddr;
        seenData = memWrData;
        busRead = 1'b0;
        busWrite = 1'b0;
        busVectorFetch = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic pe(input logic [15:0] a, input logic expRej);
        peAddr = a;
        peReq = 1'b1;
        @(negedge sys_clk);
        peReq = 1'b0;
        // Answer is a one-cycle pulse
        chk({peReject, peAccept}, {expRej, !expRej});
        @(negedge sys_clk);
    endtask
    // Full key entry in order, one byte per access
    task automatic keys(input logic [63:0] k, input logic bdc, input logic expSec);
        acc(1'b1, CFG_REG_ADDR, 8'h20, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < KEY_BYTES; i++)
        begin
            acc(1'b1, KEY_BASE_ADDR + 16'(i), k[8*i +: 8], bdc, 1'b1, 1'b0);
            chk(seenWr, 1'b0);
        end
        acc(1'b1, CFG_REG_ADDR, 8'h00, 1'b0, 1'b1, 1'b0);
        @(negedge sys_clk);
        chk(secureEngaged, expSec);
    endtask
    task automatic blank(input logic erased, input logic bdc, input logic expSec);
        blankDone = 1'b1;
        blankErased = erased;
        blankFromBdc = bdc;
        @(negedge sys_clk);
        blankDone = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(secureEngaged, expSec);
    endtask
    task automatic end_sim();
        if (errors == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    // Watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        #400000;
        errors++;
        end_sim();
    end
    initial
    begin
        @(negedge sys_clk);
        // Protection boundary rows, each after its own reset load
        foreach (peRows[r])
        begin
            boot(peRows[r][24:17], 8'h02, 1'b1);
            pe(peRows[r][16:1], peRows[r][0]);
        end
        // Working protection register only takes debug writes
        boot(8'hff, 8'h02, 1'b1);
        acc(1'b1, PROT_REG_ADDR, 8'hf8, 1'b0, 1'b1, 1'b0);
        pe(16'hffff, 1'b0);
        acc(1'b1, PROT_REG_ADDR, 8'hf8, 1'b1, 1'b0, 1'b0);
        pe(16'hfa00, 1'b1);
        // Redirect steering, interrupt vectors only; 0xfc guards the top 512 bytes
        boot(8'hfc, 8'h02, 1'b1);
        acc(1'b0, 16'hffc0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(seenAddr, 16'hfdc0);
        acc(1'b0, 16'hfffd, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(seenAddr, 16'hfdfd);
        acc(1'b0, 16'hfffe, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(seenAddr, 16'hfffe);
        boot(8'hfc, 8'h42, 1'b1);
        acc(1'b0, 16'hffe0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(seenAddr, 16'hffe0);
        boot(8'h00, 8'h02, 1'b1);
        acc(1'b0, 16'hffe0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(seenAddr, 16'hffe0);
        // Secure part: gating of unsecured and debug accesses
        boot(8'hff, 8'h83, 1'b1);
        chk({secureEngaged, debugEnableAllowed, activeBgAllowed}, 16'h0004);
        acc(1'b0, 16'hc100, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(busRdData, 8'h00);
        acc(1'b0, 16'h0100, 8'h00, 1'b1, 1'b0, 1'b0);
        chk(busRdData, 8'h00);
        acc(1'b1, 16'hc100, 8'h55, 1'b0, 1'b0, 1'b0);
        chk(seenWr, 1'b0);
        acc(1'b0, 16'hc100, 8'h00, 1'b0, 1'b1, 1'b0);
        chk(busRdData, 8'h3c);
        acc(1'b1, 16'hc100, 8'h55, 1'b0, 1'b1, 1'b0);
        chk(seenWr, 1'b1);
        chk(seenData, 8'h55);
        // Backdoor: bad last byte, debug entry, then the right key
        keys(backdoorKeyBytes ^ 64'h0100000000000000, 1'b0, 1'b1);
        keys(backdoorKeyBytes, 1'b1, 1'b1);
        keys(backdoorKeyBytes, 1'b0, 1'b0);
        // Options read shows the forced open pair, unused bits zero
        acc(1'b0, OPT_REG_ADDR, 8'h00, 1'b0, 1'b1, 1'b0);
        chk(busRdData, 8'h82);
        acc(1'b0, 16'hc1a5, 8'h00, 1'b0, 1'b0, 1'b0);
        chk({busRdData, 7'h00, debugEnableAllowed}, 16'h9901);
        // Backdoor not allowed, key ignored
        boot(8'hff, 8'h03, 1'b1);
        keys(backdoorKeyBytes, 1'b0, 1'b1);
        // Blank check unlock, background pin held low through reset
        boot(8'hff, 8'h01, 1'b0);
        chk({secureEngaged, activeBgAllowed}, 16'h0003);
        blank(1'b1, 1'b0, 1'b1);
        blank(1'b0, 1'b1, 1'b1);
        blank(1'b1, 1'b1, 1'b0);
        end_sim();
    end
endmodule

//--- key_match.sv
// Backdoor key capture and comparison sequencer
`timescale 1ns/100ps
module key_match
    import flash_guard_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Capture side
    input wire logic key_compare_access,
    input wire logic keyAllowed,
    input wire logic keyWrite,
    input wire logic [2:0] keyIdx,
    input wire logic [7:0] keyData,
    input wire logic [63:0] storedKey,
    // Result
    output logic unlockPulse
);
    import flash_guard_pkg::*;
    logic [3:0] count;         // Key bytes entered so far, in order or not
    logic allMatch;            // No mismatch or order slip yet
    logic keyAccQ;             // Previous key access level
    logic [3:0] next_count;
    logic next_allMatch;
    logic next_unlock;
    // ----------------------------------------
    // Capture and compare
    // ----------------------------------------
    // Bytes compare as they land, so no 64-bit entry store is needed
    always_comb
    begin
        next_count = count;
        next_allMatch = allMatch;
        next_unlock = 1'b0;
        if (key_compare_access && !keyAccQ)
        begin
            next_count = 4'h0;
            next_allMatch = 1'b1;
        end
        else if (key_compare_access && keyWrite)
        begin
            // Out-of-order or wrong byte spoils the attempt
            if (count >= 4'(KEY_BYTES) || {1'b0, keyIdx} != count
                || keyData != storedKey[keyIdx*8 +: 8])
            begin
                next_allMatch = 1'b0;
            end
            next_count = count + 4'h1;
        end
        if (!key_compare_access && keyAccQ)
        begin
            // A disallowed backdoor never unlocks, whatever was entered
            next_unlock = keyAllowed
                && allMatch && count == 4'(KEY_BYTES);
        end
    end
    // Registers only
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= 4'h0;
            allMatch <= 1'b0;
            keyAccQ <= 1'b0;
            unlockPulse <= 1'b0;
        end
        else
        begin
            count <= next_count;
            allMatch <= next_allMatch;
            keyAccQ <= key_compare_access;
            unlockPulse <= next_unlock;
        end
    end
    AST_KEY_DISALLOWED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !keyAllowed |=> !unlockPulse)
        else $error("unlock while backdoor disallowed");
    AST_KEY_MISMATCH: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (keyAccQ && !key_compare_access && !allMatch) |=> !unlockPulse)
        else $error("unlock despite key mismatch");
endmodule

//--- vector_redirect.sv
// Combinational address steering for interrupt vector redirection
`timescale 1ns/100ps
module vector_redirect
    import flash_guard_pkg::*;
(
    // Fetch in
    input wire logic [15:0] fetchAddr,
    input wire logic isVectorFetch,
    // Protection setup
    input wire logic redirectOn,
    input wire logic [6:0] limitBits,
    // Steered address
    output logic [15:0] steerAddr
);
    // ----------------------------------------
    // Steering
    // ----------------------------------------
    // The vector table copy lives in the top 64 bytes below the protected region
    always_comb
    begin
        steerAddr = fetchAddr;
        if (isVectorFetch && redirectOn && fetchAddr >= VEC_LO_ADDR
            && fetchAddr <= VEC_HI_ADDR)
        begin
            steerAddr = {limitBits, VEC_FILL, fetchAddr[5:0]};
        end
    end
endmodule
